// File: common/radi_cfg.svh
`ifndef RADI_CFG_SVH
`define RADI_CFG_SVH
`define RADI_PORT_OUT_A 2'h0
`define RADI_PORT_DIR_A 2'h1
`define RADI_PORT_OUT_B 2'h2
`define RADI_PORT_DIR_B 2'h3
`define RADI_FLAG_TIMER 7
`define RADI_FLAG_EDGE 6
`define RADI_ADDR_TMR_SIDE 2
`define RADI_ADDR_IRQ_EN 3
`define RADI_ADDR_WSPLIT 4
`define RADI_PRE_1 2'h0
`define RADI_PRE_8 2'h1
`define RADI_PRE_64 2'h2
`define RADI_PRE_1024 2'h3
`define RADI_EDGE_RST 1'b0
`define RADI_EDGE_EN_RST 1'b0
`endif

// File: common/radi_pkg.sv
`default_nettype none
package radi_pkg;
	typedef struct packed {
		logic cs_high;
		logic cs_low_n;
		logic mem_periph_sel_n;
		logic rw;
		logic [6:0] addr;
	} radi_bus_s;
	typedef enum logic [2:0] {
		RADI_SEL_NONE = 3'h0,
		RADI_SEL_RAM = 3'h1,
		RADI_SEL_PORT = 3'h3,
		RADI_SEL_TIMER = 3'h2
	} radi_sel_e;
endpackage
`default_nettype wire

// File: rtl/radi_decode.sv
`include "radi_cfg.svh"
`default_nettype none
module radi_decode #(
	parameter int DW = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire radi_pkg::radi_bus_s bus,
	input wire logic [DW-1:0] data_in,
	output logic [DW-1:0] data_out,
	output logic data_oe,
	output logic ram_sel,
	output logic ram_we,
	input wire logic [DW-1:0] ram_rdata,
	input wire logic [DW-1:0] port_a_pins,
	output logic [DW-1:0] port_a_output_latch,
	output logic [DW-1:0] port_a_direction,
	output logic [DW-1:0] port_b_output_latch,
	output logic [DW-1:0] port_b_direction,
	input wire logic [DW-1:0] timer_count,
	input wire logic timer_expired,
	output logic timer_load,
	output logic [DW-1:0] timer_load_value,
	output logic [1:0] timer_prescale,
	output logic irq_n_out,
	output logic irq_n_oe
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic radi_pkg::radi_sel_e sel_of(radi_pkg::radi_bus_s b);
		if (!(b.cs_high && !b.cs_low_n))
			return radi_pkg::RADI_SEL_NONE;
		if (!b.mem_periph_sel_n)
			return radi_pkg::RADI_SEL_RAM;
		if (b.addr[`RADI_ADDR_TMR_SIDE])
			return radi_pkg::RADI_SEL_TIMER;
		return radi_pkg::RADI_SEL_PORT;
	endfunction

	// One register of the four, picked by A1 A0
	function automatic logic port_hit(input logic [1:0] a,
		input logic [1:0] code);
		return a == code;
	endfunction

	// Both senses share one comparator
	function automatic logic edge_hit(input logic rising, input logic now,
		input logic prev);
		return rising ? (now && !prev) : (!now && prev);
	endfunction

	// Unused flag positions read back as zero
	function automatic logic [DW-1:0] flag_word(input logic tmr,
		input logic pin);
		logic [DW-1:0] w;
		w = '0;
		w[`RADI_FLAG_TIMER] = tmr;
		w[`RADI_FLAG_EDGE] = pin;
		return w;
	endfunction

	radi_pkg::radi_sel_e sel;
	logic wr;
	logic rd;
	logic port_wr;
	logic tmr_wr;
	logic tmr_rd;
	logic tmr_acc;
	logic flag_rd;
	logic edge_wr;
	logic tmr_irq_en_q;
	logic edge_irq_en_q;
	logic edge_rising_q;
	logic timer_flag_q;
	logic edge_flag_q;
	logic pin_prev_q;
	logic edge_seen;
	logic timer_req;
	logic edge_req;
	logic [DW-1:0] port_rdata;
	logic [DW-1:0] rdata;

	assign sel = sel_of(bus);
	assign wr = !bus.rw;
	assign rd = bus.rw;
	assign ram_sel = sel == radi_pkg::RADI_SEL_RAM;
	assign ram_we = ram_sel && wr;

	// ----------------------------------------
	// Access strobes
	// ----------------------------------------
	// Writes split on A4, reads on A0
	always_comb
	begin
		port_wr = 1'b0;
		tmr_wr = 1'b0;
		tmr_rd = 1'b0;
		flag_rd = 1'b0;
		edge_wr = 1'b0;
		case (sel)
			radi_pkg::RADI_SEL_PORT: port_wr = wr;
			radi_pkg::RADI_SEL_TIMER:
			begin
				if (wr)
				begin
					tmr_wr = bus.addr[`RADI_ADDR_WSPLIT];
					edge_wr = !bus.addr[`RADI_ADDR_WSPLIT];
				end
				else
				begin
					tmr_rd = !bus.addr[0];
					flag_rd = bus.addr[0];
				end
			end
			default: port_wr = 1'b0;
		endcase
	end

	// Reading the count touches the timer as much as writing it
	assign tmr_acc = tmr_wr || tmr_rd;

	// ----------------------------------------
	// Port registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			port_a_output_latch <= '0;
		else if (port_wr && port_hit(bus.addr[1:0], `RADI_PORT_OUT_A))
			port_a_output_latch <= data_in;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			port_a_direction <= '0;
		else if (port_wr && port_hit(bus.addr[1:0], `RADI_PORT_DIR_A))
			port_a_direction <= data_in;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			port_b_output_latch <= '0;
		else if (port_wr && port_hit(bus.addr[1:0], `RADI_PORT_OUT_B))
			port_b_output_latch <= data_in;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			port_b_direction <= '0;
		else if (port_wr && port_hit(bus.addr[1:0], `RADI_PORT_DIR_B))
			port_b_direction <= data_in;
	end

	// ----------------------------------------
	// Timer control
	// ----------------------------------------
	assign timer_load = tmr_wr;
	assign timer_load_value = data_in;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			timer_prescale <= `RADI_PRE_1;
		else if (tmr_wr)
			timer_prescale <= bus.addr[1:0];
	end

	// Reading the count with A3 low keeps the request quiet until the next timer access with A3 high
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			tmr_irq_en_q <= 1'b0;
		else if (tmr_acc)
			tmr_irq_en_q <= bus.addr[`RADI_ADDR_IRQ_EN];
	end

	// ----------------------------------------
	// Timer flag
	// ----------------------------------------
	// Expiry in the same cycle as an access wins over the clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			timer_flag_q <= 1'b0;
		else if (timer_expired)
			timer_flag_q <= 1'b1;
		else if (tmr_acc)
			timer_flag_q <= 1'b0;
	end

	// ----------------------------------------
	// Edge sense
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			edge_irq_en_q <= `RADI_EDGE_EN_RST;
			edge_rising_q <= `RADI_EDGE_RST;
		end
		else if (edge_wr)
		begin
			edge_irq_en_q <= bus.addr[1];
			edge_rising_q <= bus.addr[0];
		end
	end

	// Pin sampled directly, so direction has no say
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pin_prev_q <= 1'b0;
		else
			pin_prev_q <= port_a_pins[DW-1];
	end

	assign edge_seen = edge_hit(edge_rising_q, port_a_pins[DW-1],
		pin_prev_q);

	// ----------------------------------------
	// Edge flag
	// ----------------------------------------
	// A flag read in the cycle of an edge keeps the new edge
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			edge_flag_q <= 1'b0;
		else if (edge_seen)
			edge_flag_q <= 1'b1;
		else if (flag_rd)
			edge_flag_q <= 1'b0;
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Port A reads the pins, port B reads back its latch
	always_comb
	begin
		port_rdata = '0;
		case (bus.addr[1:0])
			`RADI_PORT_OUT_A: port_rdata = port_a_pins;
			`RADI_PORT_DIR_A: port_rdata = port_a_direction;
			`RADI_PORT_OUT_B: port_rdata = port_b_output_latch;
			`RADI_PORT_DIR_B: port_rdata = port_b_direction;
			default: port_rdata = '0;
		endcase
	end

	always_comb
	begin
		rdata = '0;
		case (sel)
			radi_pkg::RADI_SEL_RAM: rdata = ram_rdata;
			radi_pkg::RADI_SEL_PORT: rdata = port_rdata;
			radi_pkg::RADI_SEL_TIMER:
			begin
				if (bus.addr[0])
					rdata = flag_word(timer_flag_q, edge_flag_q);
				else
					rdata = timer_count;
			end
			default: rdata = '0;
		endcase
	end

	// Registered so data stays stable through the read cycle
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			data_out <= '0;
		else
			data_out <= rdata;
	end

	// Drivers stay off except in the cycle after a selected read
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			data_oe <= 1'b0;
		else
			data_oe <= rd && sel != radi_pkg::RADI_SEL_NONE;
	end

	// ----------------------------------------
	// Request
	// ----------------------------------------
	assign timer_req = timer_flag_q && tmr_irq_en_q;
	assign edge_req = edge_flag_q && edge_irq_en_q;

	// Open drain: only ever drives low, so several devices share a wire
	assign irq_n_out = 1'b0;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			irq_n_oe <= 1'b0;
		else
			irq_n_oe <= timer_req || edge_req;
	end
endmodule
`default_nettype wire

// File: bench/radi_cpu.sv
`default_nettype none
module radi_cpu (
	input wire logic sys_clk,
	input wire logic [7:0] data_out,
	output var radi_pkg::radi_bus_s bus,
	output var logic [7:0] data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		bus = '0;
		data_in = 8'h00;
	end
	// ------------------------------
	// One bus access
	// ------------------------------
	// c is {memory/periph select, rw, address}; answer a cycle later
	task automatic acc(input logic [8:0] c, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge sys_clk);
		bus <= {2'b10, c};
		data_in <= d;
		@(posedge sys_clk);
		// Released lines toggle so stale values never look valid
		bus <= {2'b00, ~c};
		data_in <= ~d;
		#1;
		q = data_out;
	endtask
endmodule
`default_nettype wire

// File: bench/radi_props.sv
`default_nettype none
module radi_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire radi_pkg::radi_bus_s bus,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic ram_sel,
	input wire logic ram_we,
	input wire logic [7:0] port_a_pins,
	input wire logic timer_expired,
	input wire logic timer_load,
	input wire logic [7:0] timer_load_value,
	input wire logic [1:0] timer_prescale,
	input wire logic irq_n_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic io;
	logic rd;
	logic p7;
	assign io = bus.cs_high & ~bus.cs_low_n & bus.mem_periph_sel_n;
	assign rd = io & bus.rw & bus.addr[2] & bus.addr[0];
	assign p7 = port_a_pins[7];
	// ------------------------------
	// Decode and flags
	// ------------------------------
	a_ram_decode: assert property (ram_sel == (bus.cs_high & ~bus.cs_low_n
		& ~bus.mem_periph_sel_n)) else $error("ram select");
	a_ram_write: assert property (ram_we == (ram_sel & ~bus.rw))
		else $error("ram write");
	a_timer_load: assert property (timer_load == (io & ~bus.rw
		& bus.addr[4] & bus.addr[2])) else $error("timer load");
	a_load_value: assert property (timer_load |->
		timer_load_value == data_in) else $error("load value");
	a_prescale_take: assert property (timer_load |=>
		timer_prescale == $past(bus.addr[1:0])) else $error("prescale");
	a_read_drive: assert property (bus.cs_high && !bus.cs_low_n
		&& bus.rw |=> data_oe) else $error("read drive");
	a_flag_bits: assert property (rd |=> data_out[5:0] == 6'h00)
		else $error("flag bits");
	// Pin held still, so only the read can explain a cleared flag
	a_edge_clear: assert property (rd && $stable(p7) ##1 $stable(p7)
		##1 rd |=> !data_out[6]) else $error("edge flag kept");
	a_timer_irq: assert property (io && !bus.rw
		&& bus.addr[4:2] == 3'h7 ##1 timer_expired && !io
		|-> ##2 irq_n_oe)
		else $error("timer request");
	c_load: cover property (timer_load);
	c_flags: cover property (rd);
	c_irq: cover property ($rose(irq_n_oe));
endmodule
bind radi_decode radi_props u_props (
	.sys_clk(sys_clk),
	.rst(rst),
	.bus(bus),
	.data_in(data_in),
	.data_out(data_out),
	.data_oe(data_oe),
	.ram_sel(ram_sel),
	.ram_we(ram_we),
	.port_a_pins(port_a_pins),
	.timer_expired(timer_expired),
	.timer_load(timer_load),
	.timer_load_value(timer_load_value),
	.timer_prescale(timer_prescale),
	.irq_n_oe(irq_n_oe)
);
`default_nettype wire

// File: bench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic te = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [7:0] rr = 8'h00;
	logic [7:0] tc = 8'h00;
	logic [7:0] q;
	logic [7:0] e [4];
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	radi_pkg::radi_bus_s bus;
	wire logic [7:0] dq;
	wire logic [7:0] di;
	wire logic [7:0] pr [4];
	wire logic [1:0] ps;
	wire logic ioe;
	radi_decode dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .data_in(di),
		.data_out(dq), .data_oe(), .ram_sel(), .ram_we(), .ram_rdata(rr),
		.port_a_pins(pa), .port_a_output_latch(pr[0]),
		.port_a_direction(pr[1]), .port_b_output_latch(pr[2]),
		.port_b_direction(pr[3]), .timer_count(tc), .timer_expired(te),
		.timer_load(), .timer_load_value(), .timer_prescale(ps),
		.irq_n_out(), .irq_n_oe(ioe));
	radi_cpu cpu (.sys_clk(sys_clk), .data_out(dq), .bus(bus), .data_in(di));
	// ------------------------------
	// Helpers
	// ------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		checked++;
		if (g !== x)
		begin
			num_errors++;
			$display("Error %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic test_done;
		if (num_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic logic [7:0] flags(input logic t, input logic g);
		return {t, g, 6'h00};
	endfunction
	task automatic pin(input logic v);
		@(posedge sys_clk);
		pa[7] <= v;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc > 2000)
		begin
			num_errors++;
			test_done();
		end
	end
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial
	begin
		void'($urandom(32'h8088c88c));
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		pa <= {1'b0, 7'($urandom)};
		cpu.acc(9'h185, 8'h00, q);
		chk(q, flags(1'b0, 1'b0));
		chk({6'h00, ps}, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			e[i] = 8'($urandom);
			cpu.acc({7'h40, i[1:0]}, e[i], q);
			chk(pr[i], e[i]);
			cpu.acc({7'h60, i[1:0]}, 8'h00, q);
			chk(q, (i == 0) ? pa : e[i]);
		end
		rr <= 8'($urandom);
		cpu.acc(9'h0ff, 8'h00, q);
		chk(q, rr);
		cpu.acc(9'h000, ~e[0], q);
		chk(pr[0], e[0]);
		for (int j = 0; j < 4; j++)
		begin
			cpu.acc({7'h45, j[1:0]}, 8'($urandom), q);
			chk({6'h00, ps}, 8'(j));
		end
		tc <= 8'($urandom);
		cpu.acc(9'h11c, 8'h20, q);
		te <= 1'b1;
		@(posedge sys_clk) te <= 1'b0;
		@(posedge sys_clk) #1 chk({7'h00, ioe}, 8'h01);
		cpu.acc(9'h185, 8'h00, q);
		chk(q, flags(1'b1, 1'b0));
		chk({7'h00, ioe}, 8'h01);
		// Timer read with the enable address bit low
		cpu.acc(9'h184, 8'h00, q);
		chk(q, tc);
		@(posedge sys_clk) #1 chk({7'h00, ioe}, 8'h00);
		pin(1'b1);
		cpu.acc(9'h185, 8'h00, q);
		chk(q, 8'h00);
		pin(1'b0);
		chk({7'h00, ioe}, 8'h00);
		cpu.acc(9'h185, 8'h00, q);
		chk(q, flags(1'b0, 1'b1));
		cpu.acc(9'h185, 8'h00, q);
		chk(q, 8'h00);
		cpu.acc(9'h107, 8'($urandom), q);
		pin(1'b1);
		chk({7'h00, ioe}, 8'h01);
		cpu.acc(9'h185, 8'h00, q);
		chk(q, flags(1'b0, 1'b1));
		@(posedge sys_clk) #1 chk({7'h00, ioe}, 8'h00);
		test_done();
	end
endmodule
`default_nettype wire
